// [rtl/clock_mode_and_low_voltage_monitor.sv]
// Clock mode control, bus clock switch and low-voltage monitor with AXI4-Lite
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module clock_mode_and_low_voltage_monitor #(
   parameter int unsigned ADDR_WIDTH = 8,
   parameter int unsigned GAP_CYCLES = clock_mode_pkg::SWITCH_GAP_CYCLES
)(
   input wire logic clock, // 200 MHz bus clock
   input wire logic resetn, // Async reset, active low
   input wire logic analogSupplyLow, // Comparator: supply below threshold
   input wire logic reducedPowerMode, // Chip in reduced-power mode
   input wire logic pllLock, // PLL lock indicator
   input wire logic oscStartupDone, // Oscillator start-up complete
   output logic lowVoltageIrq, // Low-voltage request
   output logic statusIrq, // Lock / oscillator status request
   output logic pllGateEnable, // Bus clock gate for PLL clock
   output logic oscGateEnable, // Bus clock gate for oscillator clock
   output logic oscillatorEnable, // Oscillator running
   output logic pllRefFromOsc, // PLL reference is the oscillator
   output logic pllDivideByFour, // PLL output = VCO / 4
   output logic canOscClockEnable, // Oscillator clock to CAN controller
   output logic [1:0] watchdogClockSel, // Watchdog clock source
   output logic [1:0] rtiClockSel, // Real-time interrupt clock source
   output logic [1:0] clockMode, // Present clock mode
   input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [ADDR_WIDTH-1:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready // Read data ready
);

   ////////////////////////////////////////////////////////////////////////////
   // Parameter checks, refused at elaboration
   if (ADDR_WIDTH < 4 || ADDR_WIDTH > 8)
   begin : gBadAddrWidth
      $error("ADDR_WIDTH must lie in 4..8");
   end
   // Gap counter is eight bits wide
   if (GAP_CYCLES < 1 || GAP_CYCLES > 255)
   begin : gBadGapCycles
      $error("GAP_CYCLES must lie in 1..255");
   end

   // Decode a word address against a register address
   function automatic logic hit(input logic [ADDR_WIDTH-1:0] a,
                                input logic [7:0] reg_addr);
      hit = (8'(a) & 8'hFC) == reg_addr;
   endfunction : hit

   // Map a written source code; the unused code falls back to internal ref
   function automatic logic [1:0] srcFix(input logic [1:0] code);
      srcFix = (code == 2'b11) ? clock_mode_pkg::SRC_INTERNAL_REF : code;
   endfunction : srcFix

   ////////////////////////////////////////////////////////////////////////////
   // Write channel capture: address and data taken in either order
   logic [ADDR_WIDTH-1:0] wrAddr_reg;
   logic [31:0] wrData_reg;
   logic [3:0] wrStrb_reg;
   logic awGot_reg, wGot_reg, wrDo;

   assign wrDo = awGot_reg && wGot_reg && !s_axi_bvalid;

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         awGot_reg <= 1'b0;
         wGot_reg <= 1'b0;
         wrAddr_reg <= '0;
         wrData_reg <= 32'h0000_0000;
         wrStrb_reg <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            wrAddr_reg <= s_axi_awaddr;
            awGot_reg <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wrData_reg <= s_axi_wdata;
            wrStrb_reg <= s_axi_wstrb;
            wGot_reg <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            awGot_reg <= 1'b0;
            wGot_reg <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Write response one cycle after both halves are held
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= clock_mode_pkg::RESP_OKAY;
      end
      else if (wrDo)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (hit(wrAddr_reg, clock_mode_pkg::LV_CTRL_ADDR) ||
                         hit(wrAddr_reg, clock_mode_pkg::CLK_CTRL_ADDR) ||
                         hit(wrAddr_reg, clock_mode_pkg::FLAGS_ADDR) ||
                         hit(wrAddr_reg, clock_mode_pkg::IRQ_EN_ADDR)) ?
                        clock_mode_pkg::RESP_OKAY :
                        clock_mode_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // Byte lane 0 carries every field
   logic wrLv, wrClk, wrFlg, wrIen;
   assign wrLv = wrDo && wrStrb_reg[0] &&
                 hit(wrAddr_reg, clock_mode_pkg::LV_CTRL_ADDR);
   assign wrClk = wrDo && wrStrb_reg[0] &&
                  hit(wrAddr_reg, clock_mode_pkg::CLK_CTRL_ADDR);
   assign wrFlg = wrDo && wrStrb_reg[0] &&
                  hit(wrAddr_reg, clock_mode_pkg::FLAGS_ADDR);
   assign wrIen = wrDo && wrStrb_reg[0] &&
                  hit(wrAddr_reg, clock_mode_pkg::IRQ_EN_ADDR);

   ////////////////////////////////////////////////////////////////////////////
   // Low-voltage monitor
   logic lvStatus_reg, lvStatus_next, low_voltage_irq_enable_reg, lvFlag_reg;

   assign lvStatus_next = analogSupplyLow && !reducedPowerMode;

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         lvStatus_reg <= 1'b0;
      else
         lvStatus_reg <= lvStatus_next;
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         low_voltage_irq_enable_reg <= 1'b0;
      else if (wrLv)
         low_voltage_irq_enable_reg <= wrData_reg[clock_mode_pkg::LV_IE_BIT];
   end

   // set on change; wins over a clear in the same cycle
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         lvFlag_reg <= 1'b0;
      else if (lvStatus_next != lvStatus_reg)
         lvFlag_reg <= 1'b1;
      else if (wrLv && wrData_reg[clock_mode_pkg::LV_FLAG_BIT])
         lvFlag_reg <= 1'b0;
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         lowVoltageIrq <= 1'b0;
      else
         lowVoltageIrq <= low_voltage_irq_enable_reg && lvFlag_reg;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator and lock status
   logic oscValid_reg, oscValid_next, lock_reg;
   logic [1:0] chgFlag_reg, chgIe_reg;

   assign oscValid_next = pllLock && oscillatorEnable && oscStartupDone;

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         oscValid_reg <= 1'b0;
         lock_reg <= 1'b0;
      end
      else
      begin
         oscValid_reg <= oscValid_next;
         lock_reg <= pllLock;
      end
   end

   // Change flags: hardware set beats a software one-to-clear
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         chgFlag_reg <= 2'b00;
      else
      begin
         if (pllLock != lock_reg)
            chgFlag_reg[0] <= 1'b1;
         else if (wrFlg && wrData_reg[clock_mode_pkg::LOCK_CHG_BIT])
            chgFlag_reg[0] <= 1'b0;
         if (oscValid_next != oscValid_reg)
            chgFlag_reg[1] <= 1'b1;
         else if (wrFlg && wrData_reg[clock_mode_pkg::OSCV_CHG_BIT])
            chgFlag_reg[1] <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         chgIe_reg <= 2'b00;
      else if (wrIen)
         chgIe_reg <= wrData_reg[clock_mode_pkg::OSCV_CHG_BIT:
                                 clock_mode_pkg::LOCK_CHG_BIT];
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         statusIrq <= 1'b0;
      else
         statusIrq <= |(chgFlag_reg & chgIe_reg);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clock control register
   logic pllSelect_reg, oscLost;
   assign oscLost = oscValid_reg && !oscValid_next;

   // reset into engaged internal mode (PLL selected, oscillator off)
   // oscillator loss forces PLL select, over any software write
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         pllSelect_reg <= 1'b1;
      else if (oscLost)
         pllSelect_reg <= 1'b1;
      else if (wrClk)
         pllSelect_reg <= wrData_reg[clock_mode_pkg::PLL_SEL_BIT];
   end

   // watchdog and REAL_TIME_INTERRUPT clock source choices
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         oscillatorEnable <= 1'b0;
         watchdogClockSel <= clock_mode_pkg::SRC_INTERNAL_REF;
         rtiClockSel <= clock_mode_pkg::SRC_INTERNAL_REF;
      end
      else if (wrClk)
      begin
         oscillatorEnable <= wrData_reg[clock_mode_pkg::OSC_EN_BIT];
         watchdogClockSel <= srcFix(wrData_reg[clock_mode_pkg::WDT_SRC_LSB+:2]);
         rtiClockSel <= srcFix(wrData_reg[clock_mode_pkg::RTI_SRC_LSB+:2]);
      end
   end

   // oscillator feeds the PLL reference whenever oscillatorEnable is set
   // CAN oscillator clock only while oscillator valid
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         pllRefFromOsc <= 1'b0;
         canOscClockEnable <= 1'b0;
         clockMode <= clock_mode_pkg::MODE_PLL_ENGAGED_INTERNAL;
      end
      else
      begin
         pllRefFromOsc <= oscillatorEnable;
         canOscClockEnable <= oscValid_next;
         clockMode <= !pllSelect_reg ?
                      clock_mode_pkg::MODE_PLL_BYPASSED_EXTERNAL :
                      oscillatorEnable ?
                      clock_mode_pkg::MODE_PLL_ENGAGED_EXTERNAL :
                      clock_mode_pkg::MODE_PLL_ENGAGED_INTERNAL;
      end
   end

   // VCO / 4 from oscillator loss until the PLL locks again
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         pllDivideByFour <= 1'b0;
      else if (pllLock && !lock_reg)
         pllDivideByFour <= 1'b0;
      else if (oscLost)
         pllDivideByFour <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus clock switch: break before make, with a dead gap
   clock_mode_pkg::switch_state_t swState_reg;
   logic [7:0] gapCount_reg;

   // both gates closed for GAP_CYCLES between sources
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         swState_reg <= clock_mode_pkg::SW_ON_PLL;
         gapCount_reg <= 8'h00;
         pllGateEnable <= 1'b1;
         oscGateEnable <= 1'b0;
      end
      else
      begin
         case (swState_reg)
            clock_mode_pkg::SW_ON_PLL:
               if (!pllSelect_reg && oscValid_reg)
               begin
                  swState_reg <= clock_mode_pkg::SW_GAP_TO_OSC;
                  pllGateEnable <= 1'b0;
                  gapCount_reg <= 8'(GAP_CYCLES);
               end
            clock_mode_pkg::SW_GAP_TO_OSC:
               if (pllSelect_reg || !oscValid_reg)
               begin
                  swState_reg <= clock_mode_pkg::SW_GAP_TO_PLL;
                  gapCount_reg <= 8'(GAP_CYCLES);
               end
               else if (gapCount_reg > 8'h01)
                  gapCount_reg <= gapCount_reg - 8'h01;
               else
               begin
                  swState_reg <= clock_mode_pkg::SW_ON_OSC;
                  oscGateEnable <= 1'b1;
               end
            clock_mode_pkg::SW_ON_OSC:
               // fall back to the PLL clock
               if (pllSelect_reg || !oscValid_reg)
               begin
                  swState_reg <= clock_mode_pkg::SW_GAP_TO_PLL;
                  oscGateEnable <= 1'b0;
                  gapCount_reg <= 8'(GAP_CYCLES);
               end
            clock_mode_pkg::SW_GAP_TO_PLL:
               if (gapCount_reg > 8'h01)
                  gapCount_reg <= gapCount_reg - 8'h01;
               else
               begin
                  swState_reg <= clock_mode_pkg::SW_ON_PLL;
                  pllGateEnable <= 1'b1;
               end
            default:
               swState_reg <= clock_mode_pkg::SW_GAP_TO_PLL;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read channel: data one cycle after the address is taken
   logic [31:0] rdWord;
   always_comb
   begin
      rdWord = clock_mode_pkg::READ_ZERO;
      if (hit(s_axi_araddr, clock_mode_pkg::LV_CTRL_ADDR))
      begin
         rdWord[clock_mode_pkg::LV_STATUS_BIT] = lvStatus_reg;
         rdWord[clock_mode_pkg::LV_IE_BIT] = low_voltage_irq_enable_reg;
         rdWord[clock_mode_pkg::LV_FLAG_BIT] = lvFlag_reg;
      end
      else if (hit(s_axi_araddr, clock_mode_pkg::CLK_CTRL_ADDR))
      begin
         rdWord[clock_mode_pkg::PLL_SEL_BIT] = pllSelect_reg;
         rdWord[clock_mode_pkg::OSC_EN_BIT] = oscillatorEnable;
         rdWord[clock_mode_pkg::WDT_SRC_LSB+:2] = watchdogClockSel;
         rdWord[clock_mode_pkg::RTI_SRC_LSB+:2] = rtiClockSel;
      end
      else if (hit(s_axi_araddr, clock_mode_pkg::FLAGS_ADDR))
      begin
         rdWord[clock_mode_pkg::LOCK_BIT] = lock_reg;
         rdWord[clock_mode_pkg::OSCV_BIT] = oscValid_reg;
         rdWord[clock_mode_pkg::LOCK_CHG_BIT] = chgFlag_reg[0];
         rdWord[clock_mode_pkg::OSCV_CHG_BIT] = chgFlag_reg[1];
         rdWord[clock_mode_pkg::BUS_OSC_BIT] = oscGateEnable;
         rdWord[clock_mode_pkg::MODE_LSB+:2] = clockMode;
      end
      else if (hit(s_axi_araddr, clock_mode_pkg::IRQ_EN_ADDR))
         rdWord[clock_mode_pkg::OSCV_CHG_BIT:
                clock_mode_pkg::LOCK_CHG_BIT] = chgIe_reg;
   end

   // every register readable at any time
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= clock_mode_pkg::READ_ZERO;
         s_axi_rresp <= clock_mode_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdWord;
         s_axi_rresp <= (hit(s_axi_araddr, clock_mode_pkg::LV_CTRL_ADDR) ||
                         hit(s_axi_araddr, clock_mode_pkg::CLK_CTRL_ADDR) ||
                         hit(s_axi_araddr, clock_mode_pkg::FLAGS_ADDR) ||
                         hit(s_axi_araddr, clock_mode_pkg::IRQ_EN_ADDR)) ?
                        clock_mode_pkg::RESP_OKAY :
                        clock_mode_pkg::RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   logic [7:0] deadRun_reg;
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         deadRun_reg <= 8'hFF;
      else if (pllGateEnable || oscGateEnable)
         deadRun_reg <= 8'h00;
      else if (deadRun_reg != 8'hFF)
         deadRun_reg <= deadRun_reg + 8'h01;
   end

   sequence s_oscLoss;
      oscValid_reg ##1 !oscValid_reg;
   endsequence

   property p_lvStatus;
      @(posedge clock) disable iff (!resetn)
      ##1 lvStatus_reg == $past(analogSupplyLow && !reducedPowerMode);
   endproperty
   a_lvStatus: assert property (p_lvStatus)
      else $error("low-voltage status wrong");

   property p_lvIrq;
      @(posedge clock) disable iff (!resetn)
      (low_voltage_irq_enable_reg && lvFlag_reg) |=> lowVoltageIrq;
   endproperty
   a_lvIrq: assert property (p_lvIrq)
      else $error("low-voltage request missing");

   property p_lvFlagSet;
      @(posedge clock) disable iff (!resetn)
      $changed(lvStatus_reg) |-> lvFlag_reg;
   endproperty
   a_lvFlagSet: assert property (p_lvFlagSet)
      else $error("change flag not set");

   property p_lvFlagClr;
      @(posedge clock) disable iff (!resetn)
      $fell(lvFlag_reg) |->
         $past(wrLv && wrData_reg[clock_mode_pkg::LV_FLAG_BIT]);
   endproperty
   a_lvFlagClr: assert property (p_lvFlagClr)
      else $error("change flag cleared without a one");

   property p_noLockNoOsc;
      @(posedge clock) disable iff (!resetn)
      !pllLock |=> !oscValid_reg;
   endproperty
   a_noLockNoOsc: assert property (p_noLockNoOsc)
      else $error("oscillator valid without lock");

   property p_divFour;
      @(posedge clock) disable iff (!resetn)
      // Held up to the edge that sees lock rise; cleared right after it
      s_oscLoss |-> pllDivideByFour until_with (pllLock && !lock_reg);
   endproperty
   a_divFour: assert property (p_divFour)
      else $error("divide by four not held");

   property p_canOff;
      @(posedge clock) disable iff (!resetn)
      !oscValid_reg |-> !canOscClockEnable;
   endproperty
   a_canOff: assert property (p_canOff)
      else $error("CAN oscillator clock on without valid");

   property p_fallback;
      @(posedge clock) disable iff (!resetn)
      s_oscLoss |-> pllSelect_reg ##[1:300] pllGateEnable;
   endproperty
   a_fallback: assert property (p_fallback)
      else $error("no fallback to PLL clock");

   property p_gap;
      @(posedge clock) disable iff (!resetn)
      ($rose(pllGateEnable) || $rose(oscGateEnable)) |->
         !(pllGateEnable && oscGateEnable) && $past(deadRun_reg) >= 8'(GAP_CYCLES - 1);
   endproperty
   a_gap: assert property (p_gap)
      else $error("bus clock switch gap too short");

endmodule : clock_mode_and_low_voltage_monitor

// [include/clock_mode_pkg.sv]
// Constants, register map and types of the clock mode and low-voltage block
package clock_mode_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int unsigned CLOCK_PERIOD_PS = 5000;
   // Least dead time with both bus clock gates closed during a switch
   localparam int unsigned SWITCH_GAP_NS = 20;
   localparam int unsigned SWITCH_GAP_CYCLES =
      (SWITCH_GAP_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte addresses
   localparam logic [7:0] LV_CTRL_ADDR = 8'h00;
   localparam logic [7:0] CLK_CTRL_ADDR = 8'h04;
   localparam logic [7:0] FLAGS_ADDR = 8'h08;
   localparam logic [7:0] IRQ_EN_ADDR = 8'h0C;

   // Low-voltage control fields
   localparam int unsigned LV_STATUS_BIT = 2;
   localparam int unsigned LV_IE_BIT = 1;
   localparam int unsigned LV_FLAG_BIT = 0;

   // Clock control fields
   localparam int unsigned PLL_SEL_BIT = 0;
   localparam int unsigned OSC_EN_BIT = 1;
   localparam int unsigned WDT_SRC_LSB = 2;
   localparam int unsigned RTI_SRC_LSB = 4;

   // Status flag fields; enables sit at the positions of their flags
   localparam int unsigned LOCK_BIT = 0;
   localparam int unsigned OSCV_BIT = 1;
   localparam int unsigned LOCK_CHG_BIT = 2;
   localparam int unsigned OSCV_CHG_BIT = 3;
   localparam int unsigned BUS_OSC_BIT = 4;
   localparam int unsigned MODE_LSB = 5;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [1:0]
   {
      SRC_INTERNAL_REF = 2'b00,
      SRC_OSC = 2'b01,
      SRC_RC = 2'b10
   } clk_src_t;

   typedef enum logic [1:0]
   {
      MODE_PLL_ENGAGED_INTERNAL = 2'b00,
      MODE_PLL_ENGAGED_EXTERNAL = 2'b01,
      MODE_PLL_BYPASSED_EXTERNAL = 2'b10
   } clock_mode_t;

   typedef enum logic [1:0]
   {
      SW_ON_PLL = 2'b00,
      SW_GAP_TO_OSC = 2'b01,
      SW_ON_OSC = 2'b10,
      SW_GAP_TO_PLL = 2'b11
   } switch_state_t;

endpackage : clock_mode_pkg

// [sim/clock_mode_and_low_voltage_monitor_test.sv]
// Bench for the clock mode and low-voltage monitor block
`timescale 1ns/1ps
module clock_mode_and_low_voltage_monitor_test;
`define CHK(a, b) begin numChecks++; if ((a) !== (b)) begin nMismatch++; \
 $display("unexpected at %0t: %h vs %h", $time, a, b); end end
   logic clock, resetn, supLow, reduced_power_mode, lock, oscUp;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp, wdSel, rtiSel, clockMode;
   logic lvIrq, stIrq, pllGate, oscGate, oscEn, refOsc, div4, canEn;
   int nMismatch = 0, numChecks = 0;
   clock_mode_and_low_voltage_monitor uut (.clock(clock), .resetn(resetn),
      .analogSupplyLow(supLow), .reducedPowerMode(reduced_power_mode), .pllLock(lock),
      .oscStartupDone(oscUp), .lowVoltageIrq(lvIrq), .statusIrq(stIrq),
      .pllGateEnable(pllGate), .oscGateEnable(oscGate),
      .oscillatorEnable(oscEn), .pllRefFromOsc(refOsc),
      .pllDivideByFour(div4), .canOscClockEnable(canEn),
      .watchdogClockSel(wdSel), .rtiClockSel(rtiSel), .clockMode(clockMode),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready));
   ////////////////////////////////////////////////////////////////////////////
   // Bus master; each channel released only at its own handshake edge
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w;
      aw = 1;
      w = 1;
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_bready <= 1;
      s_axi_awvalid <= 1; s_axi_wvalid <= 1;
      while (aw || w)
      begin
         @(posedge clock);
         if (aw && s_axi_awready) begin aw = 0; s_axi_awvalid <= 0; end
         if (w && s_axi_wready) begin w = 0; s_axi_wvalid <= 0; end
      end
      do @(posedge clock); while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      s_axi_bready <= 0;
      @(posedge clock);
   endtask : wr
   task rdr(input logic [7:0] a);
      s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
      do @(posedge clock); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 0;
      do @(posedge clock); while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata; resp = s_axi_rresp; s_axi_rready <= 0;
      @(posedge clock);
   endtask : rdr
   ////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task t_reset;
      rdr(8'h00); `CHK(rd, 32'h0000_0000)
      rdr(8'h04); `CHK(rd, 32'h0000_0001)
      `CHK({clockMode, pllGate, oscGate}, 4'h2)
   endtask : t_reset
   task t_lowv;
      supLow <= 1; repeat (4) @(posedge clock);
      rdr(8'h00); `CHK(rd, 32'h0000_0005)
      wr(8'h00, 32'h0000_0000); rdr(8'h00); `CHK(rd, 32'h0000_0005)
      wr(8'h00, 32'h0000_0002); rdr(8'h00); `CHK(rd, 32'h0000_0007)
      `CHK(lvIrq, 1'b1)
      wr(8'h00, 32'h0000_0003); rdr(8'h00); `CHK(rd, 32'h0000_0006)
      `CHK(lvIrq, 1'b0)
      reduced_power_mode <= 1; repeat (4) @(posedge clock);
      rdr(8'h00); `CHK(rd, 32'h0000_0003)
      wr(8'h00, 32'h0000_0005); rdr(8'h00); `CHK(rd, 32'h0000_0000)
   endtask : t_lowv
   task t_bypass;
      wr(8'h04, 32'h0000_0003); lock <= 1; oscUp <= 1;
      repeat (4) @(posedge clock);
      rdr(8'h08); `CHK(rd, 32'h0000_002F)
      wr(8'h08, 32'h0000_000C); rdr(8'h08); `CHK(rd, 32'h0000_0023)
      for (int c = 0; c < 3; c++)
      begin
         wr(8'h04, 32'h0000_0002 | (c << 2) | (c << 4));
         repeat (8) @(posedge clock);
         `CHK({wdSel, rtiSel}, {c[1:0], c[1:0]})
         `CHK({oscEn, oscGate, pllGate, refOsc, clockMode}, 6'h36)
      end
      rdr(8'h08); `CHK(rd, 32'h0000_0053)
      wr(8'h0C, 32'h0000_000C); rdr(8'h0C); `CHK(rd, 32'h0000_000C)
      lock <= 0; repeat (10) @(posedge clock);
      `CHK({pllGate, oscGate, div4, canEn, stIrq}, 5'h15)
      rdr(8'h04); `CHK(rd, 32'h0000_002B)
      lock <= 1; repeat (4) @(posedge clock);
      `CHK(div4, 1'b0)
      wr(8'h04, 32'h0000_003F); rdr(8'h04); `CHK(rd, 32'h0000_0003)
      wr(8'h10, 32'h0000_0001); `CHK(resp, 2'h2)
      rdr(8'h10); `CHK(resp, 2'h2)
   endtask : t_bypass
   ////////////////////////////////////////////////////////////////////////////
   // Both gates open at once would mean a runt on the bus clock
   always @(posedge clock) if (resetn) `CHK(pllGate & oscGate, 1'b0)
   task test_done;
      $display("checks %0d mismatches %0d", numChecks, nMismatch);
      if (nMismatch == 0 && numChecks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : test_done
   initial begin clock = 0; forever #2.5 clock = ~clock; end
   // Watchdog, far beyond the under two hundred cycles needed
   initial begin #50000; nMismatch++; test_done; end
   initial
   begin
      resetn = 0; supLow = 0; reduced_power_mode = 0; lock = 0; oscUp = 0;
      s_axi_awvalid = 0; s_axi_wvalid = 0; s_axi_arvalid = 0;
      s_axi_bready = 0; s_axi_rready = 0; s_axi_awaddr = 0;
      s_axi_araddr = 0; s_axi_wdata = 0;
      repeat (12) @(posedge clock);
      resetn <= 1;
      @(posedge clock);
      t_reset; t_lowv; t_bypass;
      test_done;
   end
endmodule : clock_mode_and_low_voltage_monitor_test
